//--- rtl/wdog_pkg.sv
/*
 * Constants shared by the watchdog and reset-cause block: register
 * offsets, bit positions, reset values and timing figures.
 * Assumes a single 20 MHz system clock and a plain register port.
 */
// Overview of operation
// - Upper four bits of the reset cause register always read zero.
// - Watchdog reset flag sets on watchdog reset; cleared by power-on or zero write.
// - Brownout flag sets on brown-out reset; cleared by power-on or zero write.
// - Pin flag sets on external reset; cleared by power-on or zero write.
// - Power-on flag sets on power-on; only a zero write clears it.
// - Interrupt flag sets on time-out in interrupt mode; vector or one-write clears.
// - Interrupt requested only with global enable and watchdog enable both set.
// - Combined mode: vector clears enable and flag, leaving reset mode.
// - Combined mode: second time-out with flag still pending causes reset.
// - Fuse off: enables select stopped, interrupt, reset, or interrupt-then-reset.
// - Fuse programmed forces system reset mode regardless of the enables.
// - Change enable clears itself four clock cycles after being set.
// - Clearing reset enable or changing period needs change enable set.
// - Reset enable held set while the watchdog reset flag is set.
// - Period is 2048 oscillator cycles shifted by code 0..9; 10..15 reserved.
// - Counter counts 128 kHz oscillator ticks; restart returns it to zero.
// - Fuse programmed locks reset enable at one, interrupt enable at zero.
// - A reset-mode time-out gives a one-cycle system reset pulse.

package wdog_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] CAUSE_OFFSET = 8'h55;
    localparam logic [7:0] CTRL_OFFSET = 8'h60;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int CAUSE_WDOG_BIT = 3;
    localparam int CAUSE_BROWN_BIT = 2;
    localparam int CAUSE_PIN_BIT = 1;
    localparam int CAUSE_PWR_BIT = 0;
    localparam int CTRL_IRQ_FLAG_BIT = 7;
    localparam int CTRL_IRQ_EN_BIT = 6;
    localparam int CTRL_SEL3_BIT = 5;
    localparam int CTRL_CHG_BIT = 4;
    localparam int CTRL_RST_EN_BIT = 3;

    // -----------------------------------------------------------------
    // Reset values and timing
    // -----------------------------------------------------------------
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int BASE_CYCLES = 2048;
    localparam int CNT_W = 21;
    localparam int CHG_WINDOW = 4;
    localparam logic [2:0] CHG_CNT_INIT = 3'h4;
    localparam int SYS_CLK_HZ = 20000000;
    localparam int OSC_HZ = 128000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_IRQ,
        MODE_RESET,
        MODE_IRQ_RESET
    } mode_type;

endpackage

//--- rtl/wdog_cfg_if.sv
/*
 * Interface carrying the watchdog configuration from the register
 * file to the counter, and the time-out event back.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps

interface wdog_cfg_if;
    logic [3:0] sel;
    logic running;
    logic restart;
    logic timeout;

    modport regs (output sel, output running, output restart,
                  input timeout);
    modport cnt (input sel, input running, input restart,
                 output timeout);
endinterface

//--- rtl/wdog_osc_tick.sv
/*
 * Divider making a one-cycle tick at the watchdog oscillator rate
 * from the system clock. Assumes the system clock is a whole
 * multiple-ish of the oscillator; fractional part is accumulated.
 */
`timescale 1ns/1ps

module wdog_osc_tick (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Tick out
    output logic o_tick
);
    localparam logic [24:0] STEP = 25'(wdog_pkg::OSC_HZ);
    localparam logic [24:0] LIMIT = 25'(wdog_pkg::SYS_CLK_HZ);

    logic [24:0] acc_reg;

    // Fractional accumulator keeps the long-run rate exact
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            acc_reg <= '0;
            o_tick <= 1'b0;
        end else if (acc_reg + STEP >= LIMIT) begin
            acc_reg <= acc_reg + STEP - LIMIT;
            o_tick <= 1'b1;
        end else begin
            acc_reg <= acc_reg + STEP;
            o_tick <= 1'b0;
        end
    end
endmodule // wdog_osc_tick

//--- rtl/wdog_counter.sv
/*
 * Watchdog counter: counts oscillator ticks and flags a time-out
 * when the selected length is reached. Assumes the tick is a
 * one-cycle pulse on the system clock.
 */
`timescale 1ns/1ps

module wdog_counter (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Oscillator tick
    input wire logic i_tick,
    // Configuration
    wdog_cfg_if.cnt cfg
);
    localparam int W = wdog_pkg::CNT_W;

    logic [W-1:0] count_reg;
    logic [W-1:0] limit;
    logic timeout_reg;

    // Period length for a select code; reserved codes clamp to longest
    function automatic logic [W-1:0] period_of(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > wdog_pkg::SEL_MAX) ? wdog_pkg::SEL_MAX : sel;
        period_of = W'(wdog_pkg::BASE_CYCLES) << s;
    endfunction

    assign limit = period_of(cfg.sel);
    assign cfg.timeout = timeout_reg;

    // Count ticks; restart and time-out both return to zero
    always_ff @(posedge i_mclk) begin
        timeout_reg <= 1'b0;
        if (i_sys_rst || cfg.restart || !cfg.running) begin
            count_reg <= '0;
        end else if (i_tick) begin
            if (count_reg + W'(1) >= limit) begin
                count_reg <= '0;
                timeout_reg <= 1'b1;
            end else begin
                count_reg <= count_reg + W'(1);
            end
        end
    end
endmodule // wdog_counter

//--- rtl/wdog_reset_cause.sv
/*
 * Watchdog timer with timed change protection and reset-cause status.
 * Registers reached over a plain port: address, write data, write and
 * read strobes, read data one cycle later. Reset-cause events arrive as
 * one-cycle pulses from the reset generators outside.
 */
`timescale 1ns/1ps

module wdog_reset_cause (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Reset cause events
    input wire logic i_poweron_event,
    input wire logic i_brownout_event,
    input wire logic i_pin_event,
    // Fuse and processor
    input wire logic i_always_on_fuse,
    input wire logic i_global_irq_enable,
    input wire logic i_vector_taken,
    input wire logic i_restart,
    // Watchdog outputs
    output logic o_irq_request,
    output logic o_sys_reset
);
    wdog_cfg_if cfg ();

    // ---------------------------------------------------------------
    // Registers and internal signals
    // ---------------------------------------------------------------
    // Reset cause flags
    logic wdog_reset_flag_reg;
    logic brownout_reset_flag_reg;
    logic pin_reset_flag_reg;
    logic poweron_reset_flag_reg;

    // Control register fields
    logic wdog_irq_flag_reg;
    logic wdog_irq_enable_reg;
    logic wdog_change_enable_reg;
    logic wdog_reset_enable_reg;
    logic [3:0] timeout_select_reg;
    logic [2:0] chg_cnt_reg;

    // Port decode
    logic wr_cause;
    logic wr_ctrl;
    logic rd_cause;
    logic rd_ctrl;
    logic chg_set;
    logic chg_last;
    logic [3:0] wsel;

    // Fuse, mode and time-out actions
    logic tick;
    logic fuse_on;
    logic eff_rst_en;
    logic eff_irq_en;
    wdog_pkg::mode_type mode;
    logic tmo_irq;
    logic tmo_reset;
    logic irq_gate;

    // Read words
    logic [7:0] cause_word;
    logic [7:0] ctrl_word;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    // Address match, shared by the write and read decoders
    function automatic logic reg_hit(input logic [7:0] addr,
        input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    assign wr_cause = i_wr && reg_hit(i_addr, wdog_pkg::CAUSE_OFFSET);
    assign wr_ctrl = i_wr && reg_hit(i_addr, wdog_pkg::CTRL_OFFSET);
    assign rd_cause = i_rd && reg_hit(i_addr, wdog_pkg::CAUSE_OFFSET);
    assign rd_ctrl = i_rd && reg_hit(i_addr, wdog_pkg::CTRL_OFFSET);
    assign wsel = {i_wdata[wdog_pkg::CTRL_SEL3_BIT], i_wdata[2:0]};
    // Opening write of the timed sequence
    assign chg_set = wr_ctrl && i_wdata[wdog_pkg::CTRL_CHG_BIT];
    // Countdown at one: the window shuts on this edge
    assign chg_last = (chg_cnt_reg == 3'h1);
    // Fuse programmed reads as zero
    assign fuse_on = !i_always_on_fuse;

    // Effective enables with fuse locks applied
    assign eff_rst_en = fuse_on | wdog_reset_enable_reg;
    assign eff_irq_en = !fuse_on & wdog_irq_enable_reg;

    // ---------------------------------------------------------------
    // Mode selection
    // ---------------------------------------------------------------
    // Fuse overrides both enables; the stored bits stay, but their
    // effect and their read-back are locked
    always_comb begin
        if (fuse_on) begin
            mode = wdog_pkg::MODE_RESET;
        end else begin
            case ({wdog_reset_enable_reg, wdog_irq_enable_reg})
                2'b00: mode = wdog_pkg::MODE_STOPPED;
                2'b01: mode = wdog_pkg::MODE_IRQ;
                2'b10: mode = wdog_pkg::MODE_RESET;
                2'b11: mode = wdog_pkg::MODE_IRQ_RESET;
                default: mode = wdog_pkg::MODE_STOPPED;
            endcase
        end
    end

    // Time-out actions per mode
    // Stopped mode takes no action at all
    always_comb begin
        tmo_irq = 1'b0;
        tmo_reset = 1'b0;
        case (mode)
            wdog_pkg::MODE_IRQ: tmo_irq = cfg.timeout;
            wdog_pkg::MODE_RESET: tmo_reset = cfg.timeout;
            wdog_pkg::MODE_IRQ_RESET: begin
                // Flag still pending means the handler never ran
                tmo_reset = cfg.timeout & wdog_irq_flag_reg;
                tmo_irq = cfg.timeout & !wdog_irq_flag_reg;
            end
            default: begin
                tmo_irq = 1'b0;
                tmo_reset = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Counter and oscillator
    // ---------------------------------------------------------------
    // Divider and counter share clock and reset. The counter holds at
    // zero while stopped, so a later enable starts a full period
    // rather than a partial one.
    assign cfg.sel = timeout_select_reg;
    assign cfg.running = (mode != wdog_pkg::MODE_STOPPED);
    assign cfg.restart = i_restart;

    wdog_osc_tick u_tick (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .o_tick(tick)
    );

    wdog_counter u_counter (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick),
        .cfg(cfg)
    );

    // ---------------------------------------------------------------
    // Reset cause flags
    // ---------------------------------------------------------------
    // Cause flags have no system reset term: they must outlive the
    // resets that they record. Power-on is the only hard clear.
    // Watchdog flag; event wins over a software clear
    always_ff @(posedge i_mclk) begin
        if (i_poweron_event) begin
            wdog_reset_flag_reg <= 1'b0;
        end else if (tmo_reset) begin
            wdog_reset_flag_reg <= 1'b1;
        end else if (wr_cause && !i_wdata[wdog_pkg::CAUSE_WDOG_BIT]) begin
            wdog_reset_flag_reg <= 1'b0;
        end
    end

    // Brown-out flag
    always_ff @(posedge i_mclk) begin
        if (i_poweron_event) begin
            brownout_reset_flag_reg <= 1'b0;
        end else if (i_brownout_event) begin
            brownout_reset_flag_reg <= 1'b1;
        end else if (wr_cause && !i_wdata[wdog_pkg::CAUSE_BROWN_BIT]) begin
            brownout_reset_flag_reg <= 1'b0;
        end
    end

    // External pin flag
    always_ff @(posedge i_mclk) begin
        if (i_poweron_event) begin
            pin_reset_flag_reg <= 1'b0;
        end else if (i_pin_event) begin
            pin_reset_flag_reg <= 1'b1;
        end else if (wr_cause && !i_wdata[wdog_pkg::CAUSE_PIN_BIT]) begin
            pin_reset_flag_reg <= 1'b0;
        end
    end

    // Power-on flag: no reset input clears it, so no i_sys_rst term
    always_ff @(posedge i_mclk) begin
        if (i_poweron_event) begin
            poweron_reset_flag_reg <= 1'b1;
        end else if (wr_cause && !i_wdata[wdog_pkg::CAUSE_PWR_BIT]) begin
            poweron_reset_flag_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Watchdog control
    // ---------------------------------------------------------------
    // Opening write sets change enable; writes in the next four
    // cycles may clear reset enable or move the period.
    // Anything else is refused, so a runaway write cannot disarm.
    // Change enable window: four cycles then self-clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wdog_change_enable_reg <= 1'b0;
            chg_cnt_reg <= '0;
        end else if (chg_set) begin
            wdog_change_enable_reg <= 1'b1;
            chg_cnt_reg <= wdog_pkg::CHG_CNT_INIT;
        end else if (wr_ctrl) begin
            // Writing zero closes the window at once
            wdog_change_enable_reg <= 1'b0;
            chg_cnt_reg <= '0;
        end else if (chg_cnt_reg != '0) begin
            chg_cnt_reg <= chg_cnt_reg - 3'h1;
            if (chg_last) begin
                wdog_change_enable_reg <= 1'b0;
            end
        end
    end

    // Reset enable: set freely, cleared only inside the window
    // Flag term keeps the watchdog armed across its own resets
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wdog_reset_enable_reg <= 1'b0;
        end else if (wdog_reset_flag_reg || tmo_reset) begin
            wdog_reset_enable_reg <= 1'b1;
        end else if (wr_ctrl) begin
            if (i_wdata[wdog_pkg::CTRL_RST_EN_BIT]) begin
                wdog_reset_enable_reg <= 1'b1;
            end else if (wdog_change_enable_reg) begin
                wdog_reset_enable_reg <= 1'b0;
            end
        end
    end

    // Period select: changes only inside the window
    // A shorter period under a high count times out early
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            timeout_select_reg <= wdog_pkg::SEL_RESET;
        end else if (wr_ctrl && wdog_change_enable_reg) begin
            timeout_select_reg <= wsel;
        end
    end

    // Interrupt enable; vector in combined mode drops to reset mode
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wdog_irq_enable_reg <= 1'b0;
        end else if (i_vector_taken && mode == wdog_pkg::MODE_IRQ_RESET) begin
            wdog_irq_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            wdog_irq_enable_reg <= i_wdata[wdog_pkg::CTRL_IRQ_EN_BIT];
        end
    end

    // Interrupt flag: set beats clear
    // A time-out beside a clear must not be lost
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wdog_irq_flag_reg <= 1'b0;
        end else if (tmo_irq) begin
            wdog_irq_flag_reg <= 1'b1;
        end else if (i_vector_taken) begin
            wdog_irq_flag_reg <= 1'b0;
        end else if (wr_ctrl && i_wdata[wdog_pkg::CTRL_IRQ_FLAG_BIT]) begin
            wdog_irq_flag_reg <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Request needs the flag, the interrupt enable unlocked by the fuse, and the processor's consent
    assign irq_gate = wdog_irq_flag_reg && eff_irq_en
        && i_global_irq_enable;

    // Interrupt request, a level one cycle behind the gate
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_irq_request <= 1'b0;
        end else begin
            o_irq_request <= irq_gate;
        end
    end

    // Reset pulse; the time-out strobe lasts one cycle, so does this
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_sys_reset <= 1'b0;
        end else begin
            o_sys_reset <= tmo_reset;
        end
    end

    // ---------------------------------------------------------------
    // Read words
    // ---------------------------------------------------------------
    // Reserved upper cause bits are wired to zero, never stored
    always_comb begin
        cause_word = 8'h00;
        cause_word[wdog_pkg::CAUSE_WDOG_BIT] = wdog_reset_flag_reg;
        cause_word[wdog_pkg::CAUSE_BROWN_BIT] = brownout_reset_flag_reg;
        cause_word[wdog_pkg::CAUSE_PIN_BIT] = pin_reset_flag_reg;
        cause_word[wdog_pkg::CAUSE_PWR_BIT] = poweron_reset_flag_reg;
    end

    // Enables read back as locked by the fuse, not as stored
    always_comb begin
        ctrl_word = {5'h00, timeout_select_reg[2:0]};
        ctrl_word[wdog_pkg::CTRL_IRQ_FLAG_BIT] = wdog_irq_flag_reg;
        ctrl_word[wdog_pkg::CTRL_IRQ_EN_BIT] = eff_irq_en;
        ctrl_word[wdog_pkg::CTRL_SEL3_BIT] = timeout_select_reg[3];
        ctrl_word[wdog_pkg::CTRL_CHG_BIT] = wdog_change_enable_reg;
        ctrl_word[wdog_pkg::CTRL_RST_EN_BIT] = eff_rst_en;
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (rd_cause) begin
            o_rdata <= cause_word;
        end else if (rd_ctrl) begin
            o_rdata <= ctrl_word;
        end else begin
            o_rdata <= 8'h00;
        end
    end
endmodule // wdog_reset_cause

//--- tb/wdog_monitor.sv
/* Port checker for the watchdog and reset-cause block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps

module wdog_monitor (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Events, fuse and processor
    input wire logic i_poweron_event,
    input wire logic i_brownout_event,
    input wire logic i_pin_event,
    input wire logic i_always_on_fuse,
    input wire logic i_global_irq_enable,
    input wire logic i_vector_taken,
    // Watchdog outputs
    input wire logic o_irq_request,
    input wire logic o_sys_reset
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    chk_cause_upper:
    assert property (i_rd && i_addr == wdog_pkg::CAUSE_OFFSET
        |=> o_rdata[7:4] == 4'h0) else $error("cause upper bits set");
    // Power-on alone leaves only its own flag
    chk_poweron_alone:
    assert property ((i_poweron_event && !i_brownout_event && !i_pin_event
        && !i_wr) ##1 (!i_brownout_event && !i_pin_event && !i_wr)
        ##1 (i_rd && i_addr == wdog_pkg::CAUSE_OFFSET)
        |=> o_rdata == 8'h01) else $error("cause after power-on");
    chk_window_closes:
    assert property ((i_wr && i_addr == wdog_pkg::CTRL_OFFSET
        && i_wdata[4] && i_wdata[3]) ##1 (!i_wr) [*6]
        ##1 (i_rd && i_addr == wdog_pkg::CTRL_OFFSET)
        |=> o_rdata[4] == 1'b0) else $error("change enable stuck");
    chk_sel_update:
    assert property ((i_wr && i_addr == wdog_pkg::CTRL_OFFSET
        && i_wdata == 8'h18) ##2 (i_wr && !i_wdata[4]
        && i_addr == wdog_pkg::CTRL_OFFSET)
        ##2 (i_rd && i_addr == wdog_pkg::CTRL_OFFSET)
        |=> (o_rdata & 8'h27) == ($past(i_wdata, 3) & 8'h27))
        else $error("select not taken in window");
    chk_fuse_lock:
    assert property (i_rd && i_addr == wdog_pkg::CTRL_OFFSET
        && !i_always_on_fuse |=> !o_rdata[6] && o_rdata[3])
        else $error("fuse lock not shown");

    // ----------------------------------------
    // Watchdog outputs
    // ----------------------------------------
    chk_reset_pulse:
    assert property (o_sys_reset |=> !o_sys_reset)
        else $error("reset pulse too long");
    chk_irq_gate:
    assert property (o_irq_request |-> $past(i_global_irq_enable))
        else $error("request without global enable");
    // Registered request may trail the vector by one cycle
    chk_vector_clears:
    assert property (i_vector_taken |-> ##[1:2] !o_irq_request)
        else $error("request kept after vector");
    chk_fuse_no_irq:
    assert property (!i_always_on_fuse && !$past(i_always_on_fuse)
        && !$past(i_always_on_fuse, 2) |-> !o_irq_request)
        else $error("request with fuse programmed");

    // Main scenarios reached
    cover property (i_rd && i_addr == wdog_pkg::CTRL_OFFSET
        && !i_always_on_fuse);
    cover property (i_poweron_event ##2 i_rd);
    cover property (i_wr && i_wdata == 8'h18 ##2 i_wr);
endmodule // wdog_monitor

bind wdog_reset_cause wdog_monitor i_mon (.i_mclk, .i_sys_rst, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_poweron_event,
    .i_brownout_event, .i_pin_event, .i_always_on_fuse,
    .i_global_irq_enable, .i_vector_taken, .o_irq_request,
    .o_sys_reset);

//--- tb/tb_top.sv
/* Self-checking bench for the watchdog and reset-cause block.
   Assumes a 20 MHz clock; no time-out fits the run length. */
`timescale 1ns/1ps
`define CHECK(got, exp, msg) begin n_compared++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module tb_top;
    localparam logic [7:0] CA = wdog_pkg::CAUSE_OFFSET;
    localparam logic [7:0] CT = wdog_pkg::CTRL_OFFSET;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [4:0] evt = 5'h00;
    logic fuse = 1'b1;
    logic gie = 1'b0;
    logic [7:0] o_rdata;
    logic o_irq_request;
    logic o_sys_reset;
    logic [7:0] rd;
    logic [7:0] e;
    int mismatches = 0;
    int n_compared = 0;

    // ----------------------------------------
    // Device and clock
    // ----------------------------------------
    wdog_reset_cause i_dut (.i_mclk, .i_sys_rst, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_poweron_event(evt[0]),
        .i_brownout_event(evt[1]), .i_pin_event(evt[2]),
        .i_always_on_fuse(fuse), .i_global_irq_enable(gie),
        .i_vector_taken(evt[3]), .i_restart(evt[4]),
        .o_irq_request, .o_sys_reset);

    initial begin
        forever #25 i_mclk = ~i_mclk;
    end

    // ----------------------------------------
    // Bus and event tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the read edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // One-cycle pulse: poweron, brownout, pin, vector, restart
    task automatic pulse(input int k);
        @(posedge i_mclk);
        evt <= 5'h01 << k;
        @(posedge i_mclk);
        evt <= 5'h00;
    endtask

    task automatic do_reset();
        @(posedge i_mclk);
        i_sys_rst <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
    endtask

    task automatic close_out();
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_poweron();
        pulse(0);
        rd_reg(CA, rd);
        `CHECK(rd, 8'h01, "cause after power-on")
        rd_reg(CT, rd);
        `CHECK(rd, 8'h00, "control reset value")
        wr_reg(8'h40, 8'hff);
        rd_reg(8'h40, rd);
        `CHECK(rd, 8'h00, "unmapped read")
    endtask

    // Cause flags: set, selective clear, survive system reset
    task automatic t_cause();
        pulse(1);
        pulse(2);
        rd_reg(CA, rd);
        `CHECK(rd, 8'h07, "brownout and pin set")
        wr_reg(CA, 8'hfb);
        rd_reg(CA, rd);
        `CHECK(rd, 8'h03, "brownout zero write")
        wr_reg(CA, 8'hf0);
        rd_reg(CA, rd);
        `CHECK(rd, 8'h00, "upper zero, flags clear")
        pulse(2);
        do_reset();
        rd_reg(CA, rd);
        `CHECK(rd, 8'h02, "pin flag kept")
        pulse(0);
        rd_reg(CA, rd);
        `CHECK(rd, 8'h01, "power-on clears others")
    endtask

    // Timed change protection of reset enable and select
    task automatic t_protect();
        wr_reg(CT, 8'h08);
        wr_reg(CT, 8'h00);
        wr_reg(CT, 8'h0d);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h08, "change outside window")
        wr_reg(CT, 8'h18);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h18, "change enable open")
        repeat (3) @(posedge i_mclk);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h08, "change enable cleared")
        wr_reg(CT, 8'h18);
        repeat (5) @(posedge i_mclk);
        wr_reg(CT, 8'h00);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h08, "late write refused")
        wr_reg(CT, 8'h18);
        wr_reg(CT, 8'h00);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h00, "timed clear")
    endtask

    task automatic t_select();
        for (int c = 0; c < 10; c++) begin
            e = {2'b00, c[3], 2'b01, c[2:0]};
            pulse(4);
            wr_reg(CT, 8'h18);
            wr_reg(CT, e);
            rd_reg(CT, rd);
            `CHECK(rd, e, "select code")
        end
        wr_reg(CT, 8'h18);
        wr_reg(CT, 8'h00);
    endtask

    task automatic t_fuse();
        @(posedge i_mclk);
        fuse <= 1'b0;
        repeat (2) @(posedge i_mclk);
        rd_reg(CT, rd);
        `CHECK(rd & 8'h48, 8'h08, "fuse locks enables")
        wr_reg(CT, 8'h40);
        rd_reg(CT, rd);
        `CHECK(rd[6], 1'b0, "irq enable locked")
        @(posedge i_mclk);
        fuse <= 1'b1;
    endtask

    // No flag without a time-out, whatever the enables
    task automatic t_irq();
        @(posedge i_mclk);
        gie <= 1'b1;
        wr_reg(CT, 8'hc0);
        pulse(3);
        pulse(4);
        rd_reg(CT, rd);
        `CHECK(rd[7], 1'b0, "flag clear")
        `CHECK(o_irq_request, 1'b0, "no request")
        `CHECK(rd[6], 1'b1, "enable kept outside combined")
        wr_reg(CT, 8'h48);
        pulse(3);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h08, "vector leaves reset mode")
        wr_reg(CT, 8'h48);
        rd_reg(CT, rd);
        `CHECK(rd, 8'h48, "combined mode re-armed")
        `CHECK(o_sys_reset, 1'b0, "no early reset")
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        do_reset();
        t_poweron();
        t_cause();
        t_protect();
        t_select();
        t_fuse();
        t_irq();
        close_out();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_mclk);
        mismatches++;
        close_out();
    end
endmodule // tb_top
